/* File: gpio_port_map.vh */
// Register indices, field positions, reset values and timing counts of the GPIO port.
// Assumes a 32-bit AHB-Lite bus; byte address is four times the register index.
//
// Overview of operation
// - Peripherals with an alternate function enabled override pin direction and pin value, except on the pin that carries the routed clock or event.
// - Override signals are internal wires only, with no software read or write path.
// - Peripheral clock or event channel 0 can drive a selected pin for its duration.
// - One pin setup write updates every pin selected in the group setup mask.
// - Four virtual port windows map real registers; access acts as the real one.
// - Direction register holds one bit per pin; one means output, zero input.
// - Direction set alias sets written ones; reading returns the direction register.
// - Direction clear alias clears written ones; reading returns the direction register.
// - Direction toggle alias inverts written ones; reading returns the direction register.
// - Output level bit drives the pin high or low only while pin is output.
// - Output set alias sets written ones; reading returns the output level register.
// - Output clear alias clears written ones; reading returns the output level register.
// - Output toggle alias inverts written ones; reading returns the output level register.
// - Input register shows pin levels regardless of direction; disabled inputs are not sampled.
// - Interrupt control holds two 2-bit enable/priority fields; upper four bits read zero.
// - First source mask selects pins feeding port interrupt 0 under their sense setting.
// - Second source mask selects pins feeding port interrupt 1 under their sense setting.
// - Pending flag sets on a matching selected pin; writing one clears it.
// - Sense codes: 000 both, 001 rising, 010 falling, 011 low, 111 disabled.
// - Each input bit passes a multi-stage synchronizer before it is read.
`ifndef GPIO_PORT_MAP_VH
`define GPIO_PORT_MAP_VH

`define IDX_DRIVE_SELECT 8'h00
`define IDX_DRIVE_SELECT_SET 8'h01
`define IDX_DRIVE_SELECT_CLR 8'h02
`define IDX_DRIVE_SELECT_FLIP 8'h03
`define IDX_DRIVE_LEVEL 8'h04
`define IDX_DRIVE_LEVEL_SET 8'h05
`define IDX_DRIVE_LEVEL_CLR 8'h06
`define IDX_DRIVE_LEVEL_FLIP 8'h07
`define IDX_SAMPLED_LEVELS 8'h08
`define IDX_IRQ_LEVEL_SELECT 8'h09
`define IDX_IRQ_A_SOURCE 8'h0A
`define IDX_IRQ_B_SOURCE 8'h0B
`define IDX_IRQ_PENDING 8'h0C
`define IDX_OUT_ROUTE 8'h0D
`define IDX_PIN_SETUP_BASE 8'h10
`define IDX_GROUP_SETUP 8'h20
`define IDX_VPORT_MAP_LO 8'h30
`define IDX_VPORT_MAP_HI 8'h31
`define IDX_VPORT_BASE 8'h40

`define RESET_BYTE 8'h00
`define IRQ_CTRL_MASK 8'h0F
`define IRQ_A_LVL_LSB 0
`define IRQ_B_LVL_LSB 2
`define PENDING_MASK 8'h03

`define SETUP_INVERT_BIT 6
`define SETUP_OPC_MSB 5
`define SETUP_OPC_LSB 3
`define SETUP_SENSE_MSB 2
`define SETUP_WIDTH 7

`define SENSE_BOTH 3'h0
`define SENSE_RISING 3'h1
`define SENSE_FALLING 3'h2
`define SENSE_LOW 3'h3
`define SENSE_OFF 3'h7

`define ROUTE_PIN_MSB 2
`define ROUTE_CLK_BIT 3
`define ROUTE_EVENT_BIT 4
`define ROUTE_MASK 8'h1F

`define READ_WAIT_CYCLES 4'h1

`endif

/* File: bit_sync3.v */
// Three-stage synchroniser for one asynchronous pin level.
// Assumes the pin is unrelated to hclk; output changes once stages two and three agree.
`timescale 1ns/1ps
module bit_sync3 (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Pin level in, settled level out
	input wire async_in,
	output reg settled
);
	reg stage1;
	reg stage2;
	reg stage3;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
			settled <= 1'b0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3) begin
				settled <= stage3;
			end
		end
	end
endmodule

/* File: pin_cell.v */
// One pin: its setup register, input synchroniser and sense detector.
// Assumes setup writes come from the register bank on the same clock.
`timescale 1ns/1ps
`include "gpio_port_map.vh"
module pin_cell (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Setup register access
	input wire setup_we,
	input wire [`SETUP_WIDTH-1:0] setup_wdata,
	output reg [`SETUP_WIDTH-1:0] setup,
	// Pin side
	input wire pad_in,
	// Sampled level and sense match
	output wire level,
	output wire hit
);
	wire synced;
	reg prev;
	wire [2:0] sense;
	wire inv_level;
	wire off;

	assign sense = setup[`SETUP_SENSE_MSB:0];
	assign off = (sense == `SENSE_OFF);

	bit_sync3 u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(pad_in),
		.settled(synced)
	);

	assign inv_level = synced ^ setup[`SETUP_INVERT_BIT];
	// A disabled input buffer reads as zero and never senses.
	assign level = off ? 1'b0 : inv_level;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			setup <= 7'h00;
			prev <= 1'b0;
		end else begin
			if (setup_we) begin
				setup <= setup_wdata;
			end
			prev <= level;
		end
	end

	assign hit = (sense == `SENSE_BOTH) ? (level != prev) :
		(sense == `SENSE_RISING) ? (level & ~prev) :
		(sense == `SENSE_FALLING) ? (~level & prev) :
		(sense == `SENSE_LOW) ? ~level : 1'b0;
endmodule

/* File: gpio_port_register_bank.v */
// Eight-pin GPIO port with its register bank on an AHB-Lite slave.
// Assumes one AHB-Lite master, whole-word single transfers, and pins outside the clock domain.
`timescale 1ns/1ps
`include "gpio_port_map.vh"
module gpio_port_register_bank #(
	parameter [3:0] PORT_ID = 4'h0
) (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// Alternate function overrides from other peripherals
	input wire [7:0] alt_dir_en,
	input wire [7:0] alt_dir,
	input wire [7:0] alt_val_en,
	input wire [7:0] alt_val,
	// Event channel 0
	input wire event_ch0,
	// Pins
	input wire [7:0] pad_i,
	output wire [7:0] pad_o,
	output reg [7:0] pad_oe,
	// Port interrupt requests with their priority fields
	output wire irq_a,
	output wire [1:0] irq_a_priority,
	output wire irq_b,
	output wire [1:0] irq_b_priority
);
	localparam [1:0] TRANS_NONSEQ = 2'b10;

	// Register state
	reg [7:0] drive_select;
	reg [7:0] drive_level;
	reg [7:0] irq_level_select;
	reg [7:0] irq_a_source_select;
	reg [7:0] irq_b_source_select;
	reg [1:0] irq_pending_bits;
	reg [7:0] group_setup_select;
	reg [7:0] out_route;
	reg [7:0] vport_map_lo;
	reg [7:0] vport_map_hi;

	// Bus pipeline state
	reg wr_pend;
	reg [3:0] rd_wait;
	wire rd_pend;
	wire rd_last;
	reg [7:0] acc_idx;
	reg acc_hit;

	// Per-pin results
	wire [7:0] sampled_levels;
	wire [7:0] sense_hit;
	wire [`SETUP_WIDTH-1:0] pin_setup [0:7];
	wire [7:0] setup_we;
	wire [7:0] setup_invert;

	// Pin drive staging
	reg [7:0] pad_level;
	reg [7:0] next_pad_level;
	reg [7:0] next_pad_oe;
	reg event_q;

	// Address translation
	reg [7:0] next_idx;
	reg next_hit;
	reg [3:0] vp_port;
	reg [7:0] raw_idx;

	wire accept;
	wire wr_now;
	wire [7:0] wbyte;
	wire setup_write;
	wire [2:0] setup_pin;
	wire [2:0] route_pin;

	// Transfer size is not decoded; every access is taken as one whole word.
	assign accept = hsel & hready & (htrans == TRANS_NONSEQ);
	assign hresp = 1'b0;
	// Reads wait a fixed number of states so that a write just before them is visible.
	// The count runs down in the data phase, and read data load in its last wait state.
	assign rd_pend = (rd_wait != 4'h0);
	assign rd_last = (rd_wait == 4'h1);
	assign hreadyout = ~rd_pend;
	assign wr_now = wr_pend & acc_hit;
	assign wbyte = hwdata[7:0];

	// Translate a virtual port window onto the real register when the map names this port.
	always @* begin
		raw_idx = haddr[9:2];
		next_idx = raw_idx;
		next_hit = 1'b1;
		vp_port = 4'h0;
		// After reset all four windows name port zero, so that port answers every window.
		if (raw_idx >= `IDX_VPORT_BASE) begin
			case (raw_idx[3:2])
				2'd0: vp_port = vport_map_lo[3:0];
				2'd1: vp_port = vport_map_lo[7:4];
				2'd2: vp_port = vport_map_hi[3:0];
				default: vp_port = vport_map_hi[7:4];
			endcase
			next_hit = (raw_idx < (`IDX_VPORT_BASE + 8'h10)) && (vp_port == PORT_ID);
			case (raw_idx[1:0])
				2'd0: next_idx = `IDX_DRIVE_SELECT;
				2'd1: next_idx = `IDX_DRIVE_LEVEL;
				2'd2: next_idx = `IDX_SAMPLED_LEVELS;
				default: next_idx = `IDX_IRQ_PENDING;
			endcase
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_wait <= 4'h0;
			acc_idx <= 8'h00;
			acc_hit <= 1'b0;
		end else begin
			if (accept) begin
				acc_idx <= next_idx;
				acc_hit <= next_hit;
			end
			wr_pend <= accept & hwrite;
			if (accept & ~hwrite) begin
				rd_wait <= `READ_WAIT_CYCLES;
			end else if (rd_pend) begin
				rd_wait <= rd_wait - 4'h1;
			end
		end
	end

	// Pin setup writes, singly or as a group under the mask.
	assign setup_write = wr_now && (acc_idx >= `IDX_PIN_SETUP_BASE) &&
		(acc_idx < (`IDX_PIN_SETUP_BASE + 8'h08));
	assign setup_pin = acc_idx[2:0];

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : pins
			assign setup_we[g] = setup_write &&
				((group_setup_select != 8'h00) ? group_setup_select[g] :
				(setup_pin == g));
			assign setup_invert[g] = pin_setup[g][`SETUP_INVERT_BIT];
			pin_cell u_pin (
				.hclk(hclk),
				.hresetn(hresetn),
				.setup_we(setup_we[g]),
				.setup_wdata(hwdata[`SETUP_WIDTH-1:0]),
				.setup(pin_setup[g]),
				.pad_in(pad_i[g]),
				.level(sampled_levels[g]),
				.hit(sense_hit[g])
			);
		end
	endgenerate

	// Register writes; aliases only touch bits written as one.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drive_select <= `RESET_BYTE;
			drive_level <= `RESET_BYTE;
			irq_level_select <= `RESET_BYTE;
			irq_a_source_select <= `RESET_BYTE;
			irq_b_source_select <= `RESET_BYTE;
			group_setup_select <= `RESET_BYTE;
			out_route <= `RESET_BYTE;
			vport_map_lo <= `RESET_BYTE;
			vport_map_hi <= `RESET_BYTE;
		end else begin
			if (setup_write) begin
				group_setup_select <= `RESET_BYTE;
			end
			if (wr_now) begin
				case (acc_idx)
					`IDX_DRIVE_SELECT: drive_select <= wbyte;
					`IDX_DRIVE_SELECT_SET: drive_select <= drive_select | wbyte;
					`IDX_DRIVE_SELECT_CLR: drive_select <= drive_select & ~wbyte;
					`IDX_DRIVE_SELECT_FLIP: drive_select <= drive_select ^ wbyte;
					`IDX_DRIVE_LEVEL: drive_level <= wbyte;
					`IDX_DRIVE_LEVEL_SET: drive_level <= drive_level | wbyte;
					`IDX_DRIVE_LEVEL_CLR: drive_level <= drive_level & ~wbyte;
					`IDX_DRIVE_LEVEL_FLIP: drive_level <= drive_level ^ wbyte;
					`IDX_IRQ_LEVEL_SELECT: irq_level_select <= wbyte & `IRQ_CTRL_MASK;
					`IDX_IRQ_A_SOURCE: irq_a_source_select <= wbyte;
					`IDX_IRQ_B_SOURCE: irq_b_source_select <= wbyte;
					`IDX_OUT_ROUTE: out_route <= wbyte & `ROUTE_MASK;
					`IDX_GROUP_SETUP: group_setup_select <= wbyte;
					`IDX_VPORT_MAP_LO: vport_map_lo <= wbyte;
					`IDX_VPORT_MAP_HI: vport_map_hi <= wbyte;
					default: ;
				endcase
			end
		end
	end

	// Pending flags: a new match in the clearing cycle keeps the flag set.
	wire [1:0] pend_set;
	wire [1:0] pend_clr;
	assign pend_set[0] = |(sense_hit & irq_a_source_select);
	assign pend_set[1] = |(sense_hit & irq_b_source_select);
	assign pend_clr = (wr_now && (acc_idx == `IDX_IRQ_PENDING)) ? wbyte[1:0] : 2'b00;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_pending_bits <= 2'b00;
		end else begin
			irq_pending_bits <= (irq_pending_bits & ~pend_clr) | pend_set;
		end
	end

	assign irq_a_priority = irq_level_select[`IRQ_A_LVL_LSB+1:`IRQ_A_LVL_LSB];
	assign irq_b_priority = irq_level_select[`IRQ_B_LVL_LSB+1:`IRQ_B_LVL_LSB];
	// A zero priority field leaves that port interrupt disabled.
	assign irq_a = irq_pending_bits[0] & (irq_a_priority != 2'b00);
	assign irq_b = irq_pending_bits[1] & (irq_b_priority != 2'b00);

	// Read data, registered in the last wait state.
	reg [7:0] rd_byte;
	always @* begin
		rd_byte = 8'h00;
		case (acc_idx)
			`IDX_DRIVE_SELECT,
			`IDX_DRIVE_SELECT_SET,
			`IDX_DRIVE_SELECT_CLR,
			`IDX_DRIVE_SELECT_FLIP: rd_byte = drive_select;
			`IDX_DRIVE_LEVEL,
			`IDX_DRIVE_LEVEL_SET,
			`IDX_DRIVE_LEVEL_CLR,
			`IDX_DRIVE_LEVEL_FLIP: rd_byte = drive_level;
			`IDX_SAMPLED_LEVELS: rd_byte = sampled_levels;
			`IDX_IRQ_LEVEL_SELECT: rd_byte = irq_level_select;
			`IDX_IRQ_A_SOURCE: rd_byte = irq_a_source_select;
			`IDX_IRQ_B_SOURCE: rd_byte = irq_b_source_select;
			`IDX_IRQ_PENDING: rd_byte = {6'h00, irq_pending_bits};
			`IDX_OUT_ROUTE: rd_byte = out_route;
			`IDX_GROUP_SETUP: rd_byte = group_setup_select;
			`IDX_VPORT_MAP_LO: rd_byte = vport_map_lo;
			`IDX_VPORT_MAP_HI: rd_byte = vport_map_hi;
			`IDX_PIN_SETUP_BASE + 8'h00: rd_byte = {1'b0, pin_setup[0]};
			`IDX_PIN_SETUP_BASE + 8'h01: rd_byte = {1'b0, pin_setup[1]};
			`IDX_PIN_SETUP_BASE + 8'h02: rd_byte = {1'b0, pin_setup[2]};
			`IDX_PIN_SETUP_BASE + 8'h03: rd_byte = {1'b0, pin_setup[3]};
			`IDX_PIN_SETUP_BASE + 8'h04: rd_byte = {1'b0, pin_setup[4]};
			`IDX_PIN_SETUP_BASE + 8'h05: rd_byte = {1'b0, pin_setup[5]};
			`IDX_PIN_SETUP_BASE + 8'h06: rd_byte = {1'b0, pin_setup[6]};
			`IDX_PIN_SETUP_BASE + 8'h07: rd_byte = {1'b0, pin_setup[7]};
			default: ;
		endcase
		if (!acc_hit) begin
			rd_byte = 8'h00;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (rd_last) begin
			hrdata <= {24'h000000, rd_byte};
		end
	end

	// Pin drive: register level, output configuration, then peripheral overrides.
	assign route_pin = out_route[`ROUTE_PIN_MSB:0];
	integer p;
	always @* begin
		next_pad_level = 8'h00;
		next_pad_oe = 8'h00;
		for (p = 0; p < 8; p = p + 1) begin
			next_pad_level[p] = drive_level[p] ^ setup_invert[p];
			next_pad_oe[p] = drive_select[p];
			case (pin_setup[p][`SETUP_OPC_MSB:`SETUP_OPC_LSB])
				3'h4, 3'h6: next_pad_oe[p] = drive_select[p] & next_pad_level[p];
				3'h5, 3'h7: next_pad_oe[p] = drive_select[p] & ~next_pad_level[p];
				default: ;
			endcase
			if (alt_dir_en[p]) begin
				next_pad_oe[p] = alt_dir[p];
			end
			if (alt_val_en[p]) begin
				next_pad_level[p] = alt_val[p];
			end
			if ((out_route[`ROUTE_CLK_BIT] | out_route[`ROUTE_EVENT_BIT]) &&
				(route_pin == p)) begin
				next_pad_oe[p] = 1'b1;
			end
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pad_level <= 8'h00;
			pad_oe <= 8'h00;
			event_q <= 1'b0;
		end else begin
			pad_level <= next_pad_level;
			pad_oe <= next_pad_oe;
			event_q <= event_ch0;
		end
	end

	// The routed pin carries the clock itself, or the event for as long as it lasts.
	// Changing the route while the clock is out can clip one clock pulse on that pin.
	genvar q;
	generate
		for (q = 0; q < 8; q = q + 1) begin : drive
			assign pad_o[q] = (route_pin != q) ? pad_level[q] :
				out_route[`ROUTE_CLK_BIT] ? hclk :
				out_route[`ROUTE_EVENT_BIT] ? event_q : pad_level[q];
		end
	endgenerate
endmodule

/* File: gpio_port_sva.sv */
// Checker for the GPIO port's bus, pin and interrupt ports.
// Assumes one AHB-Lite master whose hready is the slave's hreadyout.
`timescale 1ns/1ps
module gpio_port_sva (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Bus
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	// Overrides and pins
	input wire [7:0] alt_dir_en,
	input wire [7:0] alt_dir,
	input wire [7:0] alt_val_en,
	input wire [7:0] alt_val,
	input wire [7:0] pad_o,
	input wire [7:0] pad_oe,
	// Interrupts
	input wire irq_a,
	input wire [1:0] irq_a_priority,
	input wire irq_b,
	input wire [1:0] irq_b_priority
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire take = hsel & hready & (htrans == 2'b10);
	sequence read_phase;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence alt_held;
		(alt_dir_en == 8'hFF && alt_val_en == 8'hFF) [*2];
	endsequence
	read_wait_a: assert property (take && !hwrite |=> read_phase)
		else $error("read data phase has wrong wait");
	write_nowait_a: assert property (take && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	stall_cause_a: assert property ($fell(hreadyout) |-> $past(take && !hwrite))
		else $error("stall without a read");
	okay_resp_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	upper_zero_a: assert property (hreadyout |-> hrdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	irq_gate_a: assert property ((irq_a |-> irq_a_priority != 2'b00) and (irq_b |-> irq_b_priority != 2'b00))
		else $error("interrupt raised while disabled");
	alt_dir_a: assert property (alt_held |-> pad_oe == $past(alt_dir))
		else $error("direction override ignored");
	alt_val_a: assert property (alt_held |-> pad_o == $past(alt_val))
		else $error("value override ignored");
	reset_zero_a: assert property ($rose(hresetn) |-> pad_oe == 8'h00 && !irq_a && !irq_b)
		else $error("outputs not cleared by reset");
endmodule
bind gpio_port_register_bank gpio_port_sva gpio_port_sva_inst (.hclk, .hresetn, .hsel, .htrans,
	.hwrite, .hready, .hreadyout, .hresp, .hrdata, .alt_dir_en, .alt_dir, .alt_val_en, .alt_val,
	.pad_o, .pad_oe, .irq_a, .irq_a_priority, .irq_b, .irq_b_priority);

/* File: gpio_pins.sv */
// Board model for the eight port pins.
// Assumes board_level is where each pin settles when the port does not drive it.
`timescale 1ns/1ps
module gpio_pins (
	// Port side
	input wire [7:0] pad_o,
	input wire [7:0] pad_oe,
	// Board side
	input wire [7:0] board_level,
	output wire [7:0] pad_i
);
	assign pad_i = (pad_oe & pad_o) | (~pad_oe & board_level);
endmodule

/* File: test_gpio_port_register_bank.sv */
// Self-checking bench for the GPIO port register bank.
// Assumes the bench is the only bus master and the board model closes the pins.
`timescale 1ns/1ps
module test_gpio_port_register_bank;
	reg hclk = 1'b0;
	reg hresetn = 1'b0;
	reg hsel = 1'b0;
	reg [31:0] haddr = 32'h0;
	reg [1:0] htrans = 2'b00;
	reg hwrite = 1'b0;
	reg [2:0] hsize = 3'h2;
	reg [31:0] hwdata = 32'h0;
	reg [7:0] alt_dir_en = 8'h00, alt_dir = 8'h00, alt_val_en = 8'h00, alt_val = 8'h00;
	reg event_ch0 = 1'b0;
	reg [7:0] board_level = 8'h00;
	wire hreadyout, hresp, irq_a, irq_b;
	wire [31:0] hrdata;
	wire [7:0] pad_i, pad_o, pad_oe;
	wire [1:0] irq_a_priority, irq_b_priority;
	integer err_count = 0;
	integer checks = 0;
	integer cyc = 0;
	integer i;
	reg [31:0] rv;
	reg [3:0] seen;
	gpio_port_register_bank gpio_port_register_bank_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .alt_dir_en,
		.alt_dir, .alt_val_en, .alt_val, .event_ch0, .pad_i, .pad_o, .pad_oe, .irq_a,
		.irq_a_priority, .irq_b, .irq_b_priority);
	gpio_pins gpio_pins_inst (.pad_o, .pad_oe, .board_level, .pad_i);
	initial begin
		forever #5 hclk = ~hclk;
	end
	task close_out;
		begin
			$display("mismatches %0d, comparisons %0d", err_count, checks);
			if (err_count == 0 && checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	always @(posedge hclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_count = err_count + 1;
			close_out;
		end
	end
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// The level seen just before an edge is what that edge samples.
	task wait_ready;
		reg r;
		begin
			r = 1'b0;
			while (r !== 1'b1) begin
				@(negedge hclk);
				r = hreadyout;
				rv = hrdata;
				@(posedge hclk);
			end
		end
	endtask
	task bus(input w, input [7:0] idx, input [7:0] d);
		begin
			@(posedge hclk);
			hsel <= 1'b1;
			htrans <= 2'b10;
			hwrite <= w;
			haddr <= {22'h0, idx, 2'b00};
			wait_ready;
			hsel <= 1'b0;
			htrans <= 2'b00;
			hwdata <= {24'h0, d};
			wait_ready;
		end
	endtask
	task wr(input [7:0] idx, input [7:0] d);
		bus(1'b1, idx, d);
	endtask
	task rdc(input [7:0] idx, input [7:0] exp);
		begin
			bus(1'b0, idx, 8'h00);
			chk(rv, {24'h0, exp});
		end
	endtask
	task t_reset;
		begin
			for (i = 0; i < 14; i = i + 1)
				rdc(i[7:0], 8'h00);
			wr(8'h3F, 8'hFF);
			rdc(8'h3F, 8'h00);
		end
	endtask
	task t_input;
		begin
			board_level <= 8'hA5;
			repeat (8) @(posedge hclk);
			rdc(8'h08, 8'hA5);
		end
	endtask
	task t_alias(input [7:0] base);
		begin
			wr(base, 8'h0F);
			wr(base + 8'h01, 8'h30);
			rdc(base + 8'h01, 8'h3F);
			wr(base + 8'h02, 8'h05);
			rdc(base + 8'h02, 8'h3A);
			wr(base + 8'h03, 8'hFF);
			rdc(base + 8'h03, 8'hC5);
			rdc(base, 8'hC5);
		end
	endtask
	task t_irq;
		begin
			wr(8'h00, 8'h00);
			board_level <= 8'h04;
			wr(8'h0A, 8'h02);
			wr(8'h0B, 8'h04);
			wr(8'h11, 8'h01);
			wr(8'h12, 8'h02);
			wr(8'h09, 8'hF6);
			rdc(8'h09, 8'h06);
			repeat (8) @(posedge hclk);
			wr(8'h0C, 8'h03);
			rdc(8'h0C, 8'h00);
			board_level <= 8'h06;
			repeat (8) @(posedge hclk);
			rdc(8'h0C, 8'h01);
			@(negedge hclk);
			chk({irq_b, irq_a, irq_b_priority, irq_a_priority}, 6'h16);
			wr(8'h0C, 8'h01);
			rdc(8'h0C, 8'h00);
			board_level <= 8'h00;
			repeat (8) @(posedge hclk);
			rdc(8'h0C, 8'h02);
			@(negedge hclk);
			chk({irq_b, irq_a}, 2'h2);
			wr(8'h0C, 8'h02);
			wr(8'h11, 8'h03);
			wr(8'h0C, 8'h01);
			rdc(8'h0C, 8'h01);
			wr(8'h11, 8'h01);
			wr(8'h0C, 8'h01);
			rdc(8'h0C, 8'h00);
		end
	endtask
	task t_group;
		begin
			wr(8'h20, 8'h0C);
			wr(8'h10, 8'h07);
			rdc(8'h12, 8'h07);
			rdc(8'h13, 8'h07);
			rdc(8'h10, 8'h00);
			rdc(8'h20, 8'h00);
			board_level <= 8'hFF;
			repeat (8) @(posedge hclk);
			rdc(8'h08, 8'hF3);
			wr(8'h10, 8'h40);
			rdc(8'h08, 8'hF2);
			wr(8'h10, 8'h00);
		end
	endtask
	task t_event;
		begin
			wr(8'h0D, 8'h15);
			@(posedge hclk);
			event_ch0 <= 1'b1;
			for (i = 0; i < 4; i = i + 1) begin
				@(negedge hclk);
				seen[i] = pad_o[5];
				@(posedge hclk);
				event_ch0 <= 1'b0;
			end
			chk(seen, 4'h2);
			wr(8'h0D, 8'h0D);
			@(negedge hclk);
			#2;
			seen[0] = pad_o[5];
			@(posedge hclk);
			#2;
			seen[1] = pad_o[5];
			seen[2] = pad_oe[5];
			seen[3] = 1'b0;
			chk(seen, 4'h6);
			wr(8'h0D, 8'h00);
		end
	endtask
	task t_vport;
		begin
			wr(8'h40, 8'h81);
			rdc(8'h00, 8'h81);
			rdc(8'h41, 8'hC5);
			wr(8'h30, 8'h01);
			rdc(8'h40, 8'h00);
			wr(8'h30, 8'h00);
		end
	endtask
	task t_alt;
		begin
			@(posedge hclk);
			alt_dir_en <= 8'hFF;
			alt_dir <= 8'h55;
			alt_val_en <= 8'hFF;
			alt_val <= 8'h3C;
			repeat (3) @(posedge hclk);
			@(negedge hclk);
			chk({pad_oe, pad_o}, 16'h553C);
			rdc(8'h00, 8'h81);
			alt_dir_en <= 8'h00;
			alt_val_en <= 8'h00;
			repeat (3) @(posedge hclk);
			@(negedge hclk);
			chk({pad_oe, pad_o & pad_oe}, 16'h8181);
			wr(8'h10, 8'h28);
			repeat (2) @(negedge hclk);
			chk(pad_oe, 8'h80);
			wr(8'h10, 8'h00);
		end
	endtask
	task t_midreset;
		begin
			@(posedge hclk);
			hresetn <= 1'b0;
			repeat (3) @(posedge hclk);
			hresetn <= 1'b1;
			@(negedge hclk);
			chk({pad_oe, 6'h00, irq_b, irq_a}, 16'h0000);
			rdc(8'h00, 8'h00);
			rdc(8'h0C, 8'h00);
		end
	endtask
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_input;
		t_alias(8'h00);
		t_alias(8'h04);
		@(negedge hclk);
		chk(pad_o & pad_oe, 8'hC5);
		t_irq;
		t_group;
		t_event;
		t_vport;
		t_alt;
		t_midreset;
		close_out;
	end
endmodule
